// ==== logic/afr_defines.svh ====
/*
  Register offsets, reset values and fixed figures of the alarm flag bank.
  Assumes it is included by its bare name wherever these macros are used.
*/
`ifndef AFR_DEFINES_SVH
`define AFR_DEFINES_SVH

`define AFR_OFF_OVERVIEW 8'h10
`define AFR_OFF_TRIP_LO 8'h11
`define AFR_OFF_ACT_LO 8'h12
`define AFR_OFF_TRIP_HI 8'h13
`define AFR_OFF_ACT_HI 8'h14
`define AFR_RESET_FLAGS 8'h00
`define AFR_ABSENT_READ 8'hFF
`define AFR_MAX_CHANNELS 8
`define AFR_GROUP_CHANNELS 4

`endif

// ==== logic/afr_pkg.sv ====
/*
  Types shared by the alarm flag bank modules.
  Assumes afr_defines.svh is on the include path.
*/
`include "afr_defines.svh"

package afr_pkg;

  typedef logic [7:0] afr_byte_type;
  typedef logic [`AFR_MAX_CHANNELS-1:0] afr_chan_type;
  // Two bits per channel: bit 2c+1 is the low alarm, bit 2c the high alarm
  typedef logic [2*`AFR_MAX_CHANNELS-1:0] afr_flags_type;

  typedef struct packed {
    logic [1:0] active;
    logic [1:0] tripped;
  } afr_cell_state_type;

  typedef struct packed {
    afr_byte_type rdata;
    logic rvalid;
    logic hit;
    logic alarm;
  } afr_top_state_type;

endpackage : afr_pkg

// ==== logic/afr_flag_cell.sv ====
/*
  Active and tripped flags of one channel, low and high threshold.
  Assumes the comparator presents both conditions together with a sample strobe.
*/
`timescale 1ns/1ps

module afr_flag_cell (
  input wire logic sys_clk_in,            // System clock
  input wire logic nrst_in,               // Async reset, active low
  input wire logic sample_in,             // New compared result this cycle
  input wire logic cond_low_in,           // Result below low threshold
  input wire logic cond_high_in,          // Result above high threshold
  input wire logic clear_trip_in,         // Tripped register read this cycle
  output logic [1:0] active_out,          // {low, high} active flags
  output logic [1:0] tripped_out          // {low, high} tripped flags
);
  import afr_pkg::*;

  afr_cell_state_type state;
  afr_cell_state_type next_state;

  always_comb
  begin
    next_state = state;
    if (sample_in)
    begin
      next_state.active = {cond_low_in, cond_high_in};
    end
    if (clear_trip_in)
    begin
      // Flags whose condition still stands survive the read
      next_state.tripped = next_state.active;
    end
    if (sample_in)
    begin
      // Set applied last so a new alarm is never lost to a read
      next_state.tripped = next_state.tripped | {cond_low_in, cond_high_in};
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign active_out = state.active;
  assign tripped_out = state.tripped;

endmodule : afr_flag_cell

// ==== logic/afr_read_mux.sv ====
/*
  Address decode and read data selection for the alarm flag registers.
  Purely combinational; the caller registers the result.
*/
`timescale 1ns/1ps
`include "afr_defines.svh"

module afr_read_mux #(
  parameter int NUM_CHANNELS = 8          // 4 or 8
) (
  input wire afr_pkg::afr_byte_type addr_in,     // Register offset
  input wire afr_pkg::afr_flags_type active_in,  // Active flags, 2 per channel
  input wire afr_pkg::afr_flags_type tripped_in, // Tripped flags, 2 per channel
  output afr_pkg::afr_byte_type data_out,        // Selected read value
  output logic hit_out,                          // Offset belongs to this bank
  output logic clear_lo_out,                     // Read of tripped ch0-3
  output logic clear_hi_out                      // Read of tripped ch4-7
);
  import afr_pkg::*;

  afr_byte_type trip_lo;
  afr_byte_type trip_hi;
  afr_byte_type act_lo;
  afr_byte_type act_hi;
  afr_byte_type overview;

  // Build size is fixed at elaboration, so this is a constant rather than a net
  localparam logic full_build = (NUM_CHANNELS > `AFR_GROUP_CHANNELS);

  // Channel k of a group sits at bits 7-2k (low) and 6-2k (high)
  genvar k;
  generate
    for (k = 0; k < `AFR_GROUP_CHANNELS; k++)
    begin : g_pack
      assign trip_lo[7-2*k -: 2] = tripped_in[2*k+1 -: 2];
      assign act_lo[7-2*k -: 2] = active_in[2*k+1 -: 2];
      assign trip_hi[7-2*k -: 2] = tripped_in[2*(k+4)+1 -: 2];
      assign act_hi[7-2*k -: 2] = active_in[2*(k+4)+1 -: 2];
      assign overview[k] = |tripped_in[2*k+1 -: 2];
      assign overview[k+4] = full_build ? |tripped_in[2*(k+4)+1 -: 2] : 1'b1;
    end
  endgenerate

  always_comb
  begin
    data_out = `AFR_RESET_FLAGS;
    hit_out = 1'b1;
    clear_lo_out = 1'b0;
    clear_hi_out = 1'b0;
    case (addr_in)
      `AFR_OFF_OVERVIEW:
      begin
        data_out = overview;
      end
      `AFR_OFF_TRIP_LO:
      begin
        data_out = trip_lo;
        clear_lo_out = 1'b1;
      end
      `AFR_OFF_ACT_LO:
      begin
        data_out = act_lo;
      end
      `AFR_OFF_TRIP_HI:
      begin
        data_out = full_build ? trip_hi : `AFR_ABSENT_READ;
        clear_hi_out = full_build;
      end
      `AFR_OFF_ACT_HI:
      begin
        data_out = full_build ? act_hi : `AFR_ABSENT_READ;
      end
      default:
      begin
        hit_out = 1'b0;
      end
    endcase
  end

endmodule : afr_read_mux

// ==== logic/afr_top.sv ====
/*
  Alarm flag register bank: per-channel active and tripped flags, their
  read-only registers at 10h to 14h and the alarm output level.
  Assumes the serial interface decodes frames into one-cycle read and write
  strobes with an offset, and that the comparator reports per-channel
  threshold conditions with a sample strobe, all synchronous to sys_clk_in.
*/
`timescale 1ns/1ps
`include "afr_defines.svh"

module afr_top #(
  parameter int NUM_CHANNELS = 8                  // 8, or 4 for the small build
) (
  input wire logic sys_clk_in,                    // System clock, 100 MHz
  input wire logic nrst_in,                       // Async reset, active low
  input wire afr_pkg::afr_chan_type sample_in,    // Per channel: new result compared
  input wire afr_pkg::afr_chan_type below_low_in, // Per channel: result under low threshold
  input wire afr_pkg::afr_chan_type above_high_in,// Per channel: result over high threshold
  input wire logic reg_rd_in,                     // Register read strobe
  input wire logic reg_wr_in,                     // Register write strobe
  input wire afr_pkg::afr_byte_type reg_addr_in,  // Register offset
  input wire afr_pkg::afr_byte_type reg_wdata_in, // Write data, never stored
  output afr_pkg::afr_byte_type reg_rdata_out,    // Read data
  output logic reg_rvalid_out,                    // Read data valid, one cycle
  output logic reg_hit_out,                       // Last read hit this bank
  output logic alarm_out                          // Any tripped flag set
);
  import afr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Flag storage

  afr_flags_type active;
  afr_flags_type tripped;
  afr_byte_type mux_data;
  logic mux_hit;
  logic mux_clear_lo;
  logic mux_clear_hi;
  logic clear_lo;
  logic clear_hi;
  logic wr_ignored;

  // Clear acts at the same edge that captures the read data
  assign clear_lo = reg_rd_in & mux_clear_lo;
  assign clear_hi = reg_rd_in & mux_clear_hi;

  // No flag is writable, so a write never reaches any state
  assign wr_ignored = reg_wr_in & (|reg_wdata_in);

  genvar c;
  generate
    for (c = 0; c < `AFR_MAX_CHANNELS; c++)
    begin : g_chan
      if (c < NUM_CHANNELS)
      begin : g_live
        afr_flag_cell u_cell (
          .sys_clk_in(sys_clk_in),
          .nrst_in(nrst_in),
          .sample_in(sample_in[c]),
          .cond_low_in(below_low_in[c]),
          .cond_high_in(above_high_in[c]),
          .clear_trip_in(c < `AFR_GROUP_CHANNELS ? clear_lo : clear_hi),
          .active_out(active[2*c+1 -: 2]),
          .tripped_out(tripped[2*c+1 -: 2])
        );
      end
      else
      begin : g_absent
        // Channels missing from the small build hold no flags
        assign active[2*c+1 -: 2] = 2'h0;
        assign tripped[2*c+1 -: 2] = 2'h0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read path

  afr_read_mux #(
    .NUM_CHANNELS(NUM_CHANNELS)
  ) u_mux (
    .addr_in(reg_addr_in),
    .active_in(active),
    .tripped_in(tripped),
    .data_out(mux_data),
    .hit_out(mux_hit),
    .clear_lo_out(mux_clear_lo),
    .clear_hi_out(mux_clear_hi)
  );

  afr_top_state_type state;
  afr_top_state_type next_state;

  always_comb
  begin
    next_state = state;
    next_state.rvalid = reg_rd_in;
    // Pin follows all tripped flags, including read ones whose condition still stands
    next_state.alarm = |tripped;
    if (reg_rd_in)
    begin
      next_state.rdata = mux_data;
      next_state.hit = mux_hit;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata_out = state.rdata;
  assign reg_rvalid_out = state.rvalid;
  assign reg_hit_out = state.hit;
  assign alarm_out = state.alarm;

endmodule : afr_top

// ==== test/afr_asserts.sv ====
/*
  Port-level checker for the alarm flag bank.
  Assumes it is bound to afr_top and sees only its ports.
*/
`timescale 1ns/1ps

module afr_asserts #(
  parameter int NUM_CHANNELS = 8 // Build size
) (
  input wire logic sys_clk_in, // Clock
  input wire logic nrst_in, // Reset, low
  input wire afr_pkg::afr_chan_type sample_in, // Samples
  input wire afr_pkg::afr_chan_type below_low_in, // Low cond
  input wire afr_pkg::afr_chan_type above_high_in, // High cond
  input wire logic reg_rd_in, // Read
  input wire logic reg_wr_in, // Write
  input wire afr_pkg::afr_byte_type reg_addr_in, // Offset
  input wire afr_pkg::afr_byte_type reg_wdata_in, // Wdata
  input wire afr_pkg::afr_byte_type reg_rdata_out, // Rdata
  input wire logic reg_rvalid_out, // Valid
  input wire logic reg_hit_out, // Hit
  input wire logic alarm_out // Alarm
);
  import afr_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////
  sequence s_rd;
    reg_rd_in;
  endsequence
  sequence s_ans;
    reg_rvalid_out;
  endsequence
  property p_answer;
    s_rd |=> s_ans;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  // Writes and idle cycles must leave the read side untouched
  property p_quiet;
    !reg_rd_in |=> !reg_rvalid_out && $stable(reg_rdata_out) && $stable(reg_hit_out);
  endproperty
  a_quiet: assert property (p_quiet) else $error("read side moved");
  property p_hit;
    s_rd |=> s_ans and (reg_hit_out == ($past(reg_addr_in) inside {[8'h10:8'h14]}));
  endproperty
  a_hit: assert property (p_hit) else $error("hit wrong");
  property p_unmapped;
    reg_rd_in && !(reg_addr_in inside {[8'h10:8'h14]}) |=> reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");
  property p_absent;
    NUM_CHANNELS == 4 && reg_rd_in && reg_addr_in inside {8'h13, 8'h14} |=> reg_rdata_out == 8'hFF;
  endproperty
  a_absent: assert property (p_absent) else $error("absent not ones");
  property p_overview4;
    NUM_CHANNELS == 4 && reg_rd_in && reg_addr_in == 8'h10 |=> reg_rdata_out[7:4] == 4'hF;
  endproperty
  a_overview4: assert property (p_overview4) else $error("overview upper bits");
  // A condition sampled on a live channel must raise the alarm two cycles later; channels missing from the small build are masked out
  localparam afr_chan_type live_mask = afr_chan_type'((1 << NUM_CHANNELS) - 1);
  property p_alarm;
    |(sample_in & (below_low_in | above_high_in) & live_mask) |-> ##2 alarm_out;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_reset;
    $rose(nrst_in) |-> !alarm_out && !reg_rvalid_out && reg_rdata_out == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("not clear after reset");
endmodule : afr_asserts

// ==== test/afr_host_model.sv ====
/*
  Host controller model: one decoded read or write strobe per access.
  Assumes the bench calls access and the bank answers one cycle later.
*/
`timescale 1ns/1ps

module afr_host_model (
  input wire logic sys_clk_in, // Clock
  input wire afr_pkg::afr_byte_type rdata_in, // Read data
  input wire logic rvalid_in, // Read valid
  output logic reg_rd_out, // Read strobe
  output logic reg_wr_out, // Write strobe
  output afr_pkg::afr_byte_type reg_addr_out, // Offset
  output afr_pkg::afr_byte_type reg_wdata_out // Write data
);
  import afr_pkg::*;
  initial
  begin
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
  end
  // Released lines show the inverse so a stale offset cannot pass
  task access(input logic wr, input afr_byte_type a, input afr_byte_type wd, output afr_byte_type rd,
              output logic ok);
    @(negedge sys_clk_in);
    reg_rd_out = !wr;
    reg_wr_out = wr;
    reg_addr_out = a;
    reg_wdata_out = wd;
    @(negedge sys_clk_in);
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~wd;
    rd = rdata_in;
    ok = rvalid_in;
  endtask : access
endmodule : afr_host_model

// ==== test/alarm_flag_registers_tb.sv ====
/*
  Self-checking bench for afr_top, full and four-channel builds side by side.
  Assumes the host model and checker files are compiled before it.
*/
`timescale 1ns/1ps
`define AFR_CHK(nm, e, g) n_checks++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", nm, e, g); err_count++; end

module alarm_flag_registers_tb;
  import afr_pkg::*;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  afr_chan_type sample_in = '0;
  afr_chan_type below_low_in = '0;
  afr_chan_type above_high_in = '0;
  logic reg_rd_in, reg_wr_in, reg_rvalid_out, reg_hit_out, alarm_out, ok;
  afr_byte_type reg_addr_in, reg_wdata_in, reg_rdata_out, rdata_small, got;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  afr_host_model i_afr_host_model (.sys_clk_in, .rdata_in(reg_rdata_out), .rvalid_in(reg_rvalid_out),
    .reg_rd_out(reg_rd_in), .reg_wr_out(reg_wr_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  afr_top i_afr_top (.sys_clk_in, .nrst_in, .sample_in, .below_low_in, .above_high_in, .reg_rd_in,
    .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .reg_hit_out, .alarm_out);
  afr_top #(.NUM_CHANNELS(4)) i_afr_top_4ch (.sys_clk_in, .nrst_in, .sample_in, .below_low_in,
    .above_high_in, .reg_rd_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out(rdata_small),
    .reg_rvalid_out(), .reg_hit_out(), .alarm_out());
  ////////////////////////////////////////////////////////////////
  task report_and_stop;
    if (err_count == 0 && n_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task samp(input int c, input logic lo, input logic hi);
    @(negedge sys_clk_in);
    sample_in[c] = 1'b1;
    below_low_in[c] = lo;
    above_high_in[c] = hi;
    @(negedge sys_clk_in);
    sample_in[c] = 1'b0;
  endtask : samp
  task chk_rd(input afr_byte_type a, input afr_byte_type e);
    i_afr_host_model.access(1'b0, a, 8'h00, got, ok);
    `AFR_CHK("rvalid", 1'b1, ok)
    `AFR_CHK("rdata", e, got)
  endtask : chk_rd
  ////////////////////////////////////////////////////////////////
  task t_reset;
    for (int a = 16; a <= 20; a++)
    begin
      chk_rd(8'(a), 8'h00);
      `AFR_CHK("hit", 1'b1, reg_hit_out)
      `AFR_CHK("small", (a >= 19) ? 8'hFF : ((a == 16) ? 8'hF0 : 8'h00), rdata_small)
    end
    chk_rd(8'h20, 8'h00);
    `AFR_CHK("hit", 1'b0, reg_hit_out)
  endtask : t_reset
  task t_map;
    afr_byte_type m, ta;
    for (int c = 0; c < 8; c++)
      for (int lo = 0; lo < 2; lo++)
      begin
        m = 8'h80 >> (2 * (c % 4) + 1 - lo);
        ta = (c < 4) ? 8'h11 : 8'h13;
        samp(c, lo[0], !lo[0]);
        chk_rd(ta + 8'h01, m);
        chk_rd(8'h10, 8'h01 << c);
        `AFR_CHK("alarm", 1'b1, alarm_out)
        samp(c, 1'b0, 1'b0);
        chk_rd(ta + 8'h01, 8'h00);
        chk_rd(ta, m);
        chk_rd(ta, 8'h00);
        `AFR_CHK("alarm", 1'b0, alarm_out)
      end
  endtask : t_map
  task t_persist;
    samp(2, 1'b1, 1'b0);
    chk_rd(8'h11, 8'h08);
    chk_rd(8'h11, 8'h08);
    samp(2, 1'b0, 1'b0);
    chk_rd(8'h11, 8'h08);
    chk_rd(8'h11, 8'h00);
  endtask : t_persist
  task t_write;
    samp(0, 1'b0, 1'b1);
    samp(0, 1'b0, 1'b0);
    i_afr_host_model.access(1'b1, 8'h11, 8'hFF, got, ok);
    `AFR_CHK("wr_valid", 1'b0, ok)
    i_afr_host_model.access(1'b1, 8'h13, 8'hFF, got, ok);
    `AFR_CHK("wr_valid", 1'b0, ok)
    chk_rd(8'h11, 8'h40);
    `AFR_CHK("small", 8'h40, rdata_small)
    chk_rd(8'h11, 8'h00);
    chk_rd(8'h13, 8'h00);
    `AFR_CHK("small", 8'hFF, rdata_small)
  endtask : t_write
  ////////////////////////////////////////////////////////////////
  // Ceiling sits well above the roughly 270 cycles the sequence needs
  always @(posedge sys_clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (4) @(negedge sys_clk_in);
    nrst_in = 1'b1;
    t_reset;
    t_map;
    t_persist;
    t_write;
    report_and_stop;
  end
endmodule : alarm_flag_registers_tb

bind afr_top afr_asserts #(.NUM_CHANNELS(NUM_CHANNELS)) i_afr_asserts (.sys_clk_in, .nrst_in, .sample_in,
  .below_low_in, .above_high_in, .reg_rd_in, .reg_wr_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out,
  .reg_rvalid_out, .reg_hit_out, .alarm_out);
